// ---- pkg/sme_cfg.svh ----
// Constants for the management mode entry and exit unit
`ifndef SME_CFG_SVH
`define SME_CFG_SVH

// ==========================================================
// Management region layout
`define SME_REGION_BASE 32'h0003_0000
`define SME_REGION_SIZE 32'h0001_0000
`define SME_RAM_LOW 32'h0003_8000
`define SME_RAM_HIGH 32'h0003_FFFF
`define SME_SAVE_HIGH_OFS 32'h0000_FFFF
`define SME_SAVE_LOW_OFS 32'h0000_FE00
`define SME_SAVE_BYTES 32'h0000_0200

// ==========================================================
// Save slot offsets from the region base, filled downward
`define SME_OFS_CONTROL_ZERO 32'h0000_FFFC
`define SME_OFS_PAGE_DIR_BASE 32'h0000_FFF8
`define SME_OFS_FLAGS 32'h0000_FFF4
`define SME_OFS_INSTR_PTR 32'h0000_FFF0
`define SME_OFS_DST_INDEX 32'h0000_FFEC
`define SME_OFS_SRC_INDEX 32'h0000_FFE8
`define SME_OFS_FRAME_PTR 32'h0000_FFE4
`define SME_OFS_STACK_PTR 32'h0000_FFE0
`define SME_OFS_BASE_REG 32'h0000_FFDC
`define SME_OFS_DATA_REG 32'h0000_FFD8
`define SME_SLOT_STEP 32'h0000_0004
`define SME_SLOT_COUNT 4'hA
`define SME_SLOT_LAST 4'h9

// ==========================================================
// Register values loaded on entry
`define SME_FLAGS_ENTRY 32'h0000_0002
`define SME_DEBUG_CTRL_ENTRY 32'h0000_0400
`define SME_INSTR_PTR_ENTRY 32'h0000_8000
`define SME_CODE_SEG_ENTRY 32'h0003_0000
`define SME_DATA_SEG_ENTRY 32'h0000_0000
`define SME_SEG_LIMIT_4G 32'hFFFF_FFFF
`define SME_PROTECT_ENABLE_BIT 0
`define SME_EMULATE_COPROC_BIT 2
`define SME_TASK_SWITCHED_BIT 3
`define SME_PAGING_ENABLE_BIT 31

// ==========================================================
// Addressing limits inside the mode
`define SME_IP_WIDTH_DEFAULT 16
`define SME_FAR_BASE_WIDTH 20

`endif

// ---- pkg/sme_pkg.sv ----
// Types for the management mode entry and exit unit
package sme_pkg;

    typedef logic [31:0] sme_word_t;

    // Architectural words that pass through the save area, slot order
    typedef struct packed {
        sme_word_t control_zero;
        sme_word_t page_dir_base;
        sme_word_t flags;
        sme_word_t instr_ptr;
        sme_word_t dst_index;
        sme_word_t src_index;
        sme_word_t frame_ptr;
        sme_word_t stack_ptr;
        sme_word_t base_reg;
        sme_word_t data_reg;
    } sme_arch_s;

    // Management memory request
    typedef struct packed {
        logic req;
        logic write;
        sme_word_t addr;
        sme_word_t wdata;
    } sme_mem_req_s;

    // Mode-wide attributes handed to the core
    typedef struct packed {
        logic mode_active;
        logic region_select;
        logic real_addressing;
        logic default_size_16;
        logic real_vector_table;
        logic nmi_blocked;
        logic init_blocked;
        logic addr_bit20_mask_n;
        sme_word_t seg_limit;
    } sme_mode_s;

    typedef enum logic [2:0] {
        SME_IDLE = 3'b000,
        SME_ACK = 3'b001,
        SME_SAVE = 3'b010,
        SME_ENTER = 3'b011,
        SME_RUN = 3'b100,
        SME_RESTORE = 3'b101,
        SME_EXIT = 3'b110
    } sme_state_e;

endpackage

// ---- logic/sme_unit.sv ----
// Management mode entry, state save, resume and restore unit
`timescale 1ns/10ps
`include "sme_cfg.svh"

// Function
// - Request pin answered by active acknowledge output
// - Save state, then jump to handler
// - Resume reloads state, drops acknowledge, continues
// - Dedicated management region kept from main memory
// - Real addressing with 4-Gbyte segment limits
// - Default operand, address, stack sizes 16-bit
// - Truncate pointer; far bases limited 20 bits
// - Ignore bit-20 mask; real vector table
// - Flags loaded 0000_0002h on entry
// - Block NMI and soft init in mode
// - Debug control 0000_0400h; status untouched
// - Clear four control-zero bits, keep rest
// - Pointer 8000h, code base 30000h, segments zero
// - Region 64-Kbyte at 30000h, entry 38000h
// - Save area fills downward FFFFh to FE00h
// - Fixed slot offsets FFFCh down to FFD8h
// - Resume reloads slots as handler left them
// - Trap slot valid only for I/O cycle
// - Unused offsets receive no saved data
// - Request in stop-grant latched, served later
// - Halt keeps sampling; request wakes and enters
module sme_unit (
    // Clock, reset and enable
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // Pins from system logic
    input wire logic sys_mgmt_irq_n_in,
    input wire logic addr_bit20_mask_n_in,
    // Core status and events
    input wire logic halted_in,
    input wire logic stop_grant_in,
    input wire logic io_cycle_in,
    input wire logic resume_in,
    input wire sme_pkg::sme_arch_s arch_in,
    // Branch target check
    input wire logic branch_valid_in,
    input wire logic branch_op32_in,
    input wire logic branch_far_in,
    input wire sme_pkg::sme_word_t branch_target_in,
    input wire sme_pkg::sme_word_t branch_base_in,
    // Management memory answer
    input wire logic mem_ack_in,
    input wire sme_pkg::sme_word_t mem_rdata_in,
    // Pin to system logic
    output logic sys_mgmt_active_n_out,
    // Management memory request
    output sme_pkg::sme_mem_req_s mem_out,
    // State handed back to the core
    output sme_pkg::sme_arch_s arch_out,
    output logic arch_load_out,
    output logic entry_load_out,
    output logic halt_wake_out,
    output sme_pkg::sme_word_t debug_ctrl_out,
    output sme_pkg::sme_word_t code_seg_base_out,
    output sme_pkg::sme_word_t data_seg_base_out,
    output sme_pkg::sme_mode_s mode_out,
    output logic io_trap_valid_out,
    // Branch check result
    output sme_pkg::sme_word_t branch_target_out,
    output logic branch_fault_out
);
    import sme_pkg::*;

    // ==========================================================
    // Helpers

    // Byte address of a save slot, index 0 is the highest slot
    function automatic sme_word_t slot_addr(input logic [3:0] idx);
        sme_word_t ofs;
        ofs = `SME_OFS_CONTROL_ZERO - (32'(idx) * `SME_SLOT_STEP);
        slot_addr = `SME_REGION_BASE + ofs;
    endfunction

    // Word of the architectural record by slot index
    function automatic sme_word_t slot_word(input sme_arch_s a,
                                            input logic [3:0] idx);
        logic [9:0][31:0] w;
        w = a;
        slot_word = w[4'h9 - idx];
    endfunction

    // ==========================================================
    // Signals

    logic irq_meta;
    logic irq_sync;
    logic irq_prev;
    logic a20_meta;
    logic a20_sync;
    logic pending;
    logic irq_edge;
    logic take;
    sme_state_e state;
    sme_state_e next_state;
    logic [3:0] slot_idx;
    sme_arch_s snap;
    logic [9:0][31:0] restored;
    logic slot_done;
    logic io_seen;

    // ==========================================================
    // Pin synchronisers

    // Request pin passes two flops before any use
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_meta <= 1'b1;
            irq_sync <= 1'b1;
            irq_prev <= 1'b1;
        end else if (clk_en_in) begin
            irq_meta <= sys_mgmt_irq_n_in;
            irq_sync <= irq_meta;
            irq_prev <= irq_sync;
        end
    end

    // Address mask pin passes two flops before any use
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            a20_meta <= 1'b1;
            a20_sync <= 1'b1;
        end else if (clk_en_in) begin
            a20_meta <= addr_bit20_mask_n_in;
            a20_sync <= a20_meta;
        end
    end

    // ==========================================================
    // Request latch

    // Falling edge of the active-low request
    assign irq_edge = irq_prev & ~irq_sync;
    // Serve only when idle and not parked in stop grant
    assign take = pending & (state == SME_IDLE) & ~stop_grant_in;

    // Latched edge; a new edge wins over the clear of an old one
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pending <= 1'b0;
        end else if (clk_en_in) begin
            if (irq_edge) begin
                pending <= 1'b1;
            end else if (take) begin
                pending <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Sequencer

    // Slot counter reaches the last save slot with an answer
    assign slot_done = mem_ack_in & (slot_idx == `SME_SLOT_LAST);

    // Next state of the entry and exit sequence
    always_comb begin
        next_state = state;
        unique case (state)
            SME_IDLE: begin
                if (take) begin
                    next_state = SME_ACK;
                end
            end
            SME_ACK: begin
                next_state = SME_SAVE;
            end
            SME_SAVE: begin
                if (slot_done) begin
                    next_state = SME_ENTER;
                end
            end
            SME_ENTER: begin
                next_state = SME_RUN;
            end
            SME_RUN: begin
                if (resume_in) begin
                    next_state = SME_RESTORE;
                end
            end
            SME_RESTORE: begin
                if (slot_done) begin
                    next_state = SME_EXIT;
                end
            end
            SME_EXIT: begin
                next_state = SME_IDLE;
            end
            default: begin
                next_state = SME_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state <= SME_IDLE;
        end else if (clk_en_in) begin
            state <= next_state;
        end
    end

    // Slot index walks the ten slots downward in memory
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            slot_idx <= 4'h0;
        end else if (clk_en_in) begin
            if (state == SME_ACK || (state == SME_RUN && resume_in)) begin
                slot_idx <= 4'h0;
            end else if (mem_ack_in && mem_out.req) begin
                slot_idx <= slot_idx + 4'h1;
            end
        end
    end

    // ==========================================================
    // Captured state

    // Snapshot of core state and I/O trap qualifier at acceptance
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            snap <= '0;
            io_seen <= 1'b0;
        end else if (clk_en_in && take) begin
            snap <= arch_in;
            io_seen <= io_cycle_in;
        end
    end

    // Words read back from the save area
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            restored <= '0;
        end else if (clk_en_in && state == SME_RESTORE && mem_ack_in) begin
            restored[4'h9 - slot_idx] <= mem_rdata_in;
        end
    end

    // ==========================================================
    // Management memory port

    // Only the ten listed slots are ever addressed
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mem_out <= '0;
        end else if (clk_en_in) begin
            if (state == SME_ACK) begin
                mem_out.req <= 1'b1;
                mem_out.write <= 1'b1;
                mem_out.addr <= slot_addr(4'h0);
                mem_out.wdata <= slot_word(snap, 4'h0);
            end else if (state == SME_RUN && resume_in) begin
                mem_out.req <= 1'b1;
                mem_out.write <= 1'b0;
                mem_out.addr <= slot_addr(4'h0);
                mem_out.wdata <= '0;
            end else if (mem_out.req && mem_ack_in) begin
                if (slot_done) begin
                    mem_out <= '0;
                end else begin
                    mem_out.addr <= slot_addr(slot_idx + 4'h1);
                    mem_out.wdata <= slot_word(snap, slot_idx + 4'h1);
                end
            end
        end
    end

    // ==========================================================
    // Acknowledge pin and mode attributes

    // Acknowledge low from acceptance until restore has ended
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sys_mgmt_active_n_out <= 1'b1;
        end else if (clk_en_in) begin
            if (take) begin
                sys_mgmt_active_n_out <= 1'b0;
            end else if (state == SME_EXIT) begin
                sys_mgmt_active_n_out <= 1'b1;
            end
        end
    end

    // Attributes that hold for the whole stay in the mode
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            mode_out <= '0;
            mode_out.addr_bit20_mask_n <= 1'b1;
        end else if (clk_en_in) begin
            if (state == SME_ENTER) begin
                mode_out.mode_active <= 1'b1;
                mode_out.real_addressing <= 1'b1;
                mode_out.seg_limit <= `SME_SEG_LIMIT_4G;
                mode_out.default_size_16 <= 1'b1;
                mode_out.real_vector_table <= 1'b1;
                mode_out.nmi_blocked <= 1'b1;
                mode_out.init_blocked <= 1'b1;
            end else if (state == SME_EXIT) begin
                mode_out.mode_active <= 1'b0;
                mode_out.real_addressing <= 1'b0;
                mode_out.seg_limit <= '0;
                mode_out.default_size_16 <= 1'b0;
                mode_out.real_vector_table <= 1'b0;
                mode_out.nmi_blocked <= 1'b0;
                mode_out.init_blocked <= 1'b0;
            end
            // Region held selected while the acknowledge is low
            mode_out.region_select <= (next_state != SME_IDLE);
            // Mask pin has no effect during the mode
            if (next_state == SME_IDLE) begin
                mode_out.addr_bit20_mask_n <= a20_sync;
            end else begin
                mode_out.addr_bit20_mask_n <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Register loads toward the core

    // Entry values and restored values share one output record
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            arch_out <= '0;
            entry_load_out <= 1'b0;
            arch_load_out <= 1'b0;
        end else if (clk_en_in) begin
            entry_load_out <= (state == SME_ENTER);
            arch_load_out <= (state == SME_EXIT);
            if (state == SME_ENTER) begin
                arch_out <= snap;
                arch_out.control_zero <= snap.control_zero &
                    ~((32'h1 << `SME_PROTECT_ENABLE_BIT) |
                      (32'h1 << `SME_EMULATE_COPROC_BIT) |
                      (32'h1 << `SME_TASK_SWITCHED_BIT) |
                      (32'h1 << `SME_PAGING_ENABLE_BIT));
                arch_out.flags <= `SME_FLAGS_ENTRY;
                arch_out.instr_ptr <= `SME_INSTR_PTR_ENTRY;
            end else if (state == SME_EXIT) begin
                arch_out <= restored;
            end
        end
    end

    // Debug control and segment bases loaded on entry
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            debug_ctrl_out <= '0;
            code_seg_base_out <= '0;
            data_seg_base_out <= '0;
        end else if (clk_en_in && state == SME_ENTER) begin
            debug_ctrl_out <= `SME_DEBUG_CTRL_ENTRY;
            code_seg_base_out <= `SME_CODE_SEG_ENTRY;
            data_seg_base_out <= `SME_DATA_SEG_ENTRY;
        end
    end

    // Wake pulse when a halted core is taken into the mode
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            halt_wake_out <= 1'b0;
            io_trap_valid_out <= 1'b0;
        end else if (clk_en_in) begin
            halt_wake_out <= take & halted_in;
            if (state == SME_ENTER) begin
                io_trap_valid_out <= io_seen;
            end else if (state == SME_EXIT) begin
                io_trap_valid_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Branch target check

    // Short transfers drop the upper pointer half; far bases checked
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            branch_target_out <= '0;
            branch_fault_out <= 1'b0;
        end else if (clk_en_in && branch_valid_in) begin
            if (mode_out.mode_active && !branch_op32_in) begin
                branch_target_out <= {16'h0000,
                    branch_target_in[`SME_IP_WIDTH_DEFAULT-1:0]};
            end else begin
                branch_target_out <= branch_target_in;
            end
            branch_fault_out <= mode_out.mode_active && branch_far_in &&
                (branch_base_in[31:`SME_FAR_BASE_WIDTH] != 12'h000);
        end
    end

endmodule

// ---- test/sme_unit_asserts.sv ----
// Port checks for the management mode unit
`timescale 1ns/10ps
module sme_unit_asserts (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Watched inputs
    input wire logic mem_ack_in,
    input wire logic branch_valid_in,
    input wire logic branch_op32_in,
    // Watched outputs
    input wire logic sys_mgmt_active_n_out,
    input wire sme_pkg::sme_mem_req_s mem_out,
    input wire sme_pkg::sme_arch_s arch_out,
    input wire logic arch_load_out,
    input wire logic entry_load_out,
    input wire sme_pkg::sme_word_t debug_ctrl_out,
    input wire sme_pkg::sme_word_t code_seg_base_out,
    input wire sme_pkg::sme_word_t data_seg_base_out,
    input wire sme_pkg::sme_mode_s mode_out,
    input wire sme_pkg::sme_word_t branch_target_out
);
    import sme_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // =====
    // Save and restore steps
    sequence s_first_save;
        mem_out.req && mem_out.write && mem_out.addr == 32'h0003_FFFC;
    endsequence
    sequence s_last_ack;
        mem_out.req && mem_ack_in && mem_out.addr == 32'h0003_FFD8;
    endsequence
    property p_ack_first;
        $fell(sys_mgmt_active_n_out) |=> s_first_save;
    endproperty
    a_ack_first: assert property (p_ack_first)
        else $error("first save write missing after acknowledge");
    property p_req_in_mode;
        mem_out.req |-> !sys_mgmt_active_n_out;
    endproperty
    a_req_in_mode: assert property (p_req_in_mode)
        else $error("memory access without acknowledge");
    property p_window;
        mem_out.req |-> mem_out.addr inside {[32'h0003_FFD8:32'h0003_FFFC]}
            && mem_out.addr[1:0] == 2'h0;
    endproperty
    a_window: assert property (p_window)
        else $error("access outside the save slots");
    property p_step;
        mem_out.req && mem_ack_in && mem_out.addr != 32'h0003_FFD8 |=>
            mem_out.req && mem_out.addr == $past(mem_out.addr) - 32'h4;
    endproperty
    a_step: assert property (p_step)
        else $error("slot address did not step down by four");
    property p_drop;
        s_last_ack |=> !mem_out.req;
    endproperty
    a_drop: assert property (p_drop)
        else $error("request held after lowest slot");
    property p_hold;
        mem_out.req && !mem_ack_in |=> mem_out.req &&
            $stable(mem_out.addr) && $stable(mem_out.wdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request changed before answer");
    property p_entry;
        entry_load_out |-> arch_out.flags == 32'h0000_0002 &&
            arch_out.instr_ptr == 32'h0000_8000 &&
            arch_out.control_zero[31] == 1'b0 &&
            arch_out.control_zero[3:2] == 2'h0 &&
            arch_out.control_zero[0] == 1'b0 &&
            debug_ctrl_out == 32'h0000_0400 &&
            code_seg_base_out == 32'h0003_0000 &&
            data_seg_base_out == 32'h0000_0000;
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry register values wrong");
    property p_mode;
        entry_load_out |-> mode_out.mode_active && mode_out.region_select &&
            mode_out.real_addressing && mode_out.default_size_16 &&
            mode_out.real_vector_table && mode_out.nmi_blocked &&
            mode_out.init_blocked && mode_out.seg_limit == 32'hFFFF_FFFF;
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode attributes wrong on entry");
    property p_branch;
        $past(branch_valid_in) && $past(mode_out.mode_active) &&
            !$past(branch_op32_in) |-> branch_target_out[31:16] == 16'h0;
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch target not cut to 16 bits");
    property p_exit;
        $rose(arch_load_out) |-> sys_mgmt_active_n_out &&
            !mode_out.mode_active;
    endproperty
    a_exit: assert property (p_exit)
        else $error("acknowledge still low after restore");
endmodule
bind sme_unit sme_unit_asserts u_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .mem_ack_in(mem_ack_in),
    .branch_valid_in(branch_valid_in), .branch_op32_in(branch_op32_in),
    .sys_mgmt_active_n_out(sys_mgmt_active_n_out), .mem_out(mem_out),
    .arch_out(arch_out), .arch_load_out(arch_load_out),
    .entry_load_out(entry_load_out), .debug_ctrl_out(debug_ctrl_out),
    .code_seg_base_out(code_seg_base_out),
    .data_seg_base_out(data_seg_base_out), .mode_out(mode_out),
    .branch_target_out(branch_target_out)
);

// ---- test/sme_mem_model.sv ----
// Management memory model for save and restore
`timescale 1ns/10ps
module sme_mem_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Answer delay in cycles
    input wire logic [3:0] lat_in,
    // Request from the unit
    input wire sme_pkg::sme_mem_req_s mem_in,
    // Answer to the unit
    output logic ack_out,
    output sme_pkg::sme_word_t rdata_out
);
    import sme_pkg::*;
    sme_word_t mem [0:15];
    logic [3:0] cnt;
    int nwr = 0;
    int bad = 0;
    // One word per ack; idle read data toggles
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ack_out <= 1'b0;
            cnt <= 4'h0;
            rdata_out <= 32'h5A5A_5A5A;
        end else if (ack_out || !mem_in.req) begin
            ack_out <= 1'b0;
            cnt <= 4'h0;
            rdata_out <= ~rdata_out;
        end else if (cnt >= lat_in) begin
            ack_out <= 1'b1;
            rdata_out <= mem[mem_in.addr[5:2]];
            if (mem_in.write) begin
                mem[mem_in.addr[5:2]] <= mem_in.wdata;
                nwr <= nwr + 1;
            end
            // RAM exists only in the upper half of the region
            if (mem_in.addr < 32'h0003_8000) begin
                bad <= bad + 1;
            end
        end else begin
            cnt <= cnt + 4'h1;
            rdata_out <= ~rdata_out;
        end
    end
endmodule

// ---- test/sme_unit_test.sv ----
// Bench for the management mode unit
`timescale 1ns/10ps
module sme_unit_test;
    import sme_pkg::*;
    logic clk_in, reset_n_in, clk_en_in, irq_n, a20_n, halted, stop_g;
    logic io_cyc, resume, br_valid, br_op32, br_far, mem_ack;
    logic active_n, arch_load, entry_load, wake, io_valid, br_fault;
    logic [3:0] lat;
    sme_arch_s arch_in, arch_out;
    sme_word_t br_target, br_base, rdata, debug_ctrl, code_base, data_base;
    sme_word_t br_out;
    sme_word_t w [0:9];
    sme_mem_req_s mem;
    sme_mode_s mode;
    int miscompares = 0;
    int n_compared = 0;
    localparam int ack_b = 3;
    localparam int ld_b = 2;
    localparam int ent_b = 1;
    localparam int wake_b = 0;
    wire [3:0] sig = {active_n, arch_load, entry_load, wake};
    // =====
    // Design and memory
    sme_unit dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .sys_mgmt_irq_n_in(irq_n), .addr_bit20_mask_n_in(a20_n),
        .halted_in(halted), .stop_grant_in(stop_g), .io_cycle_in(io_cyc),
        .resume_in(resume), .arch_in(arch_in), .branch_valid_in(br_valid),
        .branch_op32_in(br_op32), .branch_far_in(br_far),
        .branch_target_in(br_target), .branch_base_in(br_base),
        .mem_ack_in(mem_ack), .mem_rdata_in(rdata),
        .sys_mgmt_active_n_out(active_n), .mem_out(mem),
        .arch_out(arch_out), .arch_load_out(arch_load),
        .entry_load_out(entry_load), .halt_wake_out(wake),
        .debug_ctrl_out(debug_ctrl), .code_seg_base_out(code_base),
        .data_seg_base_out(data_base), .mode_out(mode),
        .io_trap_valid_out(io_valid), .branch_target_out(br_out),
        .branch_fault_out(br_fault)
    );
    sme_mem_model u_mem (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .lat_in(lat),
        .mem_in(mem), .ack_out(mem_ack), .rdata_out(rdata)
    );
    // Clock at 100 ns
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task chk(input sme_word_t got, input sme_word_t exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Bounded wait for one status output
    task wt(input int b, input logic v);
        int k;
        k = 0;
        while (sig[b] !== v && k < 300) begin
            tick(1);
            k++;
        end
        chk({31'h0, sig[b]}, {31'h0, v});
    endtask
    task pulse_req();
        irq_n = 1'b0;
        tick(1);
        irq_n = 1'b1;
    endtask
    task resume_from_sysmgmt();
        tick(2);
        resume = 1'b1;
        tick(1);
        resume = 1'b0;
        wt(ld_b, 1'b1);
    endtask
    task summarize();
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        summarize();
    end
    // Test sequence
    initial begin
        clk_en_in = 1'b1;
        reset_n_in = 1'b0;
        irq_n = 1'b1;
        a20_n = 1'b1;
        halted = 1'b0;
        stop_g = 1'b0;
        io_cyc = 1'b0;
        resume = 1'b0;
        br_valid = 1'b0;
        br_op32 = 1'b0;
        br_far = 1'b0;
        br_target = 32'h0;
        br_base = 32'h0;
        lat = 4'h2;
        for (int i = 0; i < 10; i++) begin
            w[i] = (i == 0) ? 32'hFFFF_FFFF : 32'h1357_0000 + i;
            arch_in[319 - 32 * i -: 32] = w[i];
        end
        tick(5);
        reset_n_in = 1'b1;
        tick(3);
        chk({31'h0, active_n}, 32'h1);
        a20_n = 1'b0;
        io_cyc = 1'b1;
        tick(3);
        chk({31'h0, mode.addr_bit20_mask_n}, 32'h0);
        pulse_req();
        wt(ack_b, 1'b0);
        wt(ent_b, 1'b1);
        chk(arch_out.flags, 32'h0000_0002);
        chk(arch_out.instr_ptr, 32'h0000_8000);
        chk(arch_out.control_zero, 32'h7FFF_FFF2);
        chk(arch_out.stack_ptr, w[7]);
        chk(debug_ctrl, 32'h0000_0400);
        chk(code_base, 32'h0003_0000);
        chk(data_base, 32'h0);
        chk(mode.seg_limit, 32'hFFFF_FFFF);
        chk({24'h0, mode[39:32]}, 32'hFF);
        chk({31'h0, io_valid}, 32'h1);
        for (int i = 0; i < 10; i++) chk(u_mem.mem[15 - i], w[i]);
        chk(u_mem.nwr, 32'hA);
        chk(u_mem.bad, 32'h0);
        br_valid = 1'b1;
        br_far = 1'b1;
        br_target = 32'h1234_5678;
        br_base = 32'h0010_0000;
        tick(1);
        chk(br_out, 32'h0000_5678);
        chk({31'h0, br_fault}, 32'h1);
        br_op32 = 1'b1;
        br_base = 32'h000F_0000;
        tick(1);
        chk(br_out, 32'h1234_5678);
        chk({31'h0, br_fault}, 32'h0);
        br_valid = 1'b0;
        pulse_req();
        tick(20);
        chk(u_mem.nwr, 32'hA);
        chk({31'h0, active_n}, 32'h0);
        u_mem.mem[13] = 32'h0000_0246;
        u_mem.mem[6] = 32'hDEAD_BEEF;
        io_cyc = 1'b0;
        resume_from_sysmgmt();
        chk(arch_out.flags, 32'h0000_0246);
        chk(arch_out.data_reg, 32'hDEAD_BEEF);
        chk(arch_out.control_zero, 32'hFFFF_FFFF);
        chk({31'h0, active_n}, 32'h1);
        wt(ack_b, 1'b0);
        wt(ent_b, 1'b1);
        chk({31'h0, io_valid}, 32'h0);
        chk(u_mem.nwr, 32'h14);
        resume_from_sysmgmt();
        lat = 4'h0;
        stop_g = 1'b1;
        pulse_req();
        tick(10);
        clk_en_in = 1'b0;
        stop_g = 1'b0;
        tick(4);
        chk({31'h0, active_n}, 32'h1);
        clk_en_in = 1'b1;
        wt(ack_b, 1'b0);
        wt(ent_b, 1'b1);
        resume_from_sysmgmt();
        halted = 1'b1;
        pulse_req();
        wt(wake_b, 1'b1);
        halted = 1'b0;
        wt(ack_b, 1'b0);
        wt(ent_b, 1'b1);
        resume_from_sysmgmt();
        summarize();
    end
endmodule
